// File: rtl/pvi_top.sv
/*
  Eight-source vectored priority interrupt controller with AHB-Lite
  register slave, nested service levels and an event interrupt output.
  Assumes synchronous inputs, a zero-wait AHB-Lite master and a processor
  that raises vector_fetch while reading its interrupt vector.
*/
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
module pvi_top
  import pvi_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [NUM_SRC-2:0]   src_req,
  input  wire logic                 port8_bit7,
  input  wire logic                 vector_fetch,
  input  wire logic                 cpu_off,
  output pvi_cpu_t                  cpu,
  output pvi_pin_t                  infrared_input_pin,
  output logic                      evt_irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0]            hrdata_ff;
  logic                   hreadyout_ff;
  logic                   hresp_ff;
  logic                   wr_ff;
  logic [7:0]             waddr_ff;
  logic [7:0]             ctrl_ff;
  logic [LVL_W-1:0]       prio_ff [NUM_SRC];
  logic [NUM_SRC-1:0]     src_d_ff;
  logic [NUM_SRC-1:0]     pend_ff;
  logic [NUM_SRC-1:0]     serv_ff;
  logic                   blk_ff;
  logic                   vf_d_ff;
  logic                   fetching_ff;
  pvi_cpu_t               cpu_ff;
  pvi_pin_t               pin_ff;
  logic [EVT_W-1:0]       evt_ff;
  logic [EVT_W-1:0]       evten_ff;
  logic                   evt_irq_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic                   addr_ph;
  logic                   wr_ret;
  logic                   wr_ctrl;
  logic                   wr_clr;
  logic                   wr_en;
  logic                   cmd_clr;
  logic                   cmd_allow;
  logic [NUM_SRC-1:0]     src_now;
  logic [NUM_SRC-1:0]     edge_set;
  logic [LVL_W-1:0]       cur_lvl;
  logic [LVL_W-1:0]       best_lvl;
  logic [SRC_W-1:0]       best_src;
  logic                   best_vld;
  logic                   ack;
  logic                   ret_ok;
  logic [NUM_SRC-1:0]     ret_mask;
  logic [31:0]            nxt_rdata;
  logic [EVT_W-1:0]       evt_set;

  assign addr_ph   = hsel & hready & htrans[1];
  assign wr_ret    = wr_ff & (waddr_ff == ADDR_RETURN);
  assign wr_ctrl   = wr_ff & (waddr_ff == ADDR_CTRL);
  assign wr_clr    = wr_ff & (waddr_ff == ADDR_EVTCLR);
  assign wr_en     = wr_ff & (waddr_ff == ADDR_EVTEN);
  // Commands fire only on the write itself, low means active
  assign cmd_clr   = wr_ctrl & ~hwdata[CTL_CLR_PEND];   // R14 R10
  assign cmd_allow = wr_ctrl & ~hwdata[CTL_ALLOW_ONE];  // R14

  // ----------------------------------------------------------------
  // Request edge capture
  // ----------------------------------------------------------------
  // Sources 0..6 latch on a rising edge, source 7 on a pin fall
  assign src_now  = {~port8_bit7, src_req};              // R16
  assign edge_set = src_now & ~src_d_ff;                 // R01

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_d_ff <= '0;
    end else begin
      src_d_ff <= src_now;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  always_comb begin
    cur_lvl = '0;
    for (int l = 1; l < NUM_SRC; l++) begin
      if (serv_ff[l]) begin
        cur_lvl = LVL_W'(l);
      end
    end
  end

  always_comb begin
    best_lvl = cur_lvl;
    best_src = '0;
    best_vld = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Strictly higher only, so the lowest number keeps a tie
      if (pend_ff[i] && prio_ff[i] > best_lvl) begin  // R05 R18 R02
        best_lvl = prio_ff[i];
        best_src = SRC_W'(i);
        best_vld = 1'b1;
      end
    end
  end

  // Highest in-service level is the one that completes
  always_comb begin
    ret_mask = '0;
    ret_mask[cur_lvl] = 1'b1;
  end

  assign ret_ok = wr_ret & (cur_lvl != '0);
  assign ack    = vector_fetch & ~vf_d_ff & ~cpu_ff.irq_n;

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= '0;
    end else begin
      // New edges win over clear-all and over acceptance
      pend_ff <= (pend_ff & ~({NUM_SRC{cmd_clr}})                 // R11
                  & ~(ack ? (NUM_SRC'(1) << cpu_ff.vec_src) : '0))
                 | edge_set;                                      // R06 R13
    end
  end

  // ----------------------------------------------------------------
  // Service nesting
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serv_ff <= '0;
    end else begin
      serv_ff <= (serv_ff & ~(ret_ok ? ret_mask : '0))            // R07
                 | (ack ? (NUM_SRC'(1) << prio_ff[cpu_ff.vec_src]) : '0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_ff <= 1'b0;
    end else if (ack && !ctrl_ff[CTL_DIS_AFTER]) begin
      blk_ff <= 1'b1;                                             // R12
    end else if (cmd_allow) begin
      blk_ff <= 1'b0;                                             // R12
    end
  end

  // ----------------------------------------------------------------
  // Processor side
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vf_d_ff     <= 1'b0;
      fetching_ff <= 1'b0;
    end else begin
      vf_d_ff     <= vector_fetch;
      fetching_ff <= vector_fetch;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_ff <= '{irq_n: 1'b1, vec_src: '0};
    end else begin
      // Request goes out the edge after the flag is set
      cpu_ff.irq_n <= ~(best_vld & ~ack                           // R03 R15
                        & ctrl_ff[CTL_GLB_DIS]                    // R13
                        & ~(blk_ff & ~ctrl_ff[CTL_DIS_AFTER]));   // R12
      // Frozen while the vector is being read
      if (!vector_fetch && !fetching_ff) begin
        cpu_ff.vec_src <= best_src;                               // R04 R19
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ff <= '{out: 1'b1, oe: 1'b0};
    end else begin
      pin_ff.out <= cpu_ff.irq_n;                                 // R17
      pin_ff.oe  <= cpu_off;                                      // R17
    end
  end

  // ----------------------------------------------------------------
  // Control and priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RST;                                        // R10
    end else if (wr_ctrl) begin
      ctrl_ff <= hwdata[7:0];                                     // R14
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_ff[i] <= '0;
      end
    end else if (wr_ff) begin
      for (int r = 0; r < NUM_SRC / 2; r++) begin
        if (waddr_ff == ADDR_PRIO0 + 8'(4 * r)) begin             // R08 R09
          prio_ff[2*r]   <= hwdata[PRIO_LO_POS +: LVL_W];
          prio_ff[2*r+1] <= hwdata[PRIO_HI_POS +: LVL_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status, enable and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    evt_set              = '0;
    evt_set[EVT_ACCEPT]  = ack;
    evt_set[EVT_RETURN]  = ret_ok;
    evt_set[EVT_CLEARED] = cmd_clr;
    evt_set[EVT_BAD_RET] = wr_ret & ~ret_ok;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_ff <= '0;
    end else begin
      evt_ff <= (evt_ff & ~(wr_clr ? hwdata[EVT_W-1:0] : '0)) | evt_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evten_ff <= '0;
    end else if (wr_en) begin
      evten_ff <= hwdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_irq_ff <= 1'b0;
    end else begin
      evt_irq_ff <= |(evt_ff & evten_ff);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    unique case (haddr[7:0])
      ADDR_CTRL:  nxt_rdata[7:0] = ctrl_ff;
      ADDR_PRIO0,
      ADDR_PRIO1,
      ADDR_PRIO2,
      ADDR_PRIO3: begin
        // Pair index is word index minus two
        nxt_rdata[PRIO_LO_POS +: LVL_W] = prio_ff[{~haddr[3], haddr[2], 1'b0}];
        nxt_rdata[PRIO_HI_POS +: LVL_W] = prio_ff[{~haddr[3], haddr[2], 1'b1}];
      end
      ADDR_EVT:   nxt_rdata[EVT_W-1:0] = evt_ff;
      ADDR_EVTEN: nxt_rdata[EVT_W-1:0] = evten_ff;
      ADDR_STATE: begin
        nxt_rdata[ST_PEND_POS +: NUM_SRC] = pend_ff;
        nxt_rdata[ST_SERV_POS +: NUM_SRC] = serv_ff;
        nxt_rdata[ST_VEC_POS +: SRC_W]    = cpu_ff.vec_src;
        nxt_rdata[ST_BLK_POS]             = blk_ff;
        nxt_rdata[ST_IRQ_POS]             = ~cpu_ff.irq_n;
      end
      default:    nxt_rdata = '0;
    endcase
    if (haddr[31:8] != '0) begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff    <= 1'b0;
      waddr_ff <= '0;
    end else begin
      wr_ff    <= addr_ph & hwrite & (haddr[31:8] == '0);
      waddr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (addr_ph && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_ff <= HRESP_OKAY;
    end else begin
      hresp_ff <= HRESP_OKAY;
    end
  end

  assign hrdata             = hrdata_ff;
  assign hreadyout          = hreadyout_ff;
  assign hresp              = hresp_ff;
  assign cpu                = cpu_ff;
  assign infrared_input_pin = pin_ff;
  assign evt_irq            = evt_irq_ff;

endmodule

// File: rtl/pvi_pkg.sv
/*
  Constants, register map and carrier types of the eight-source vectored
  priority interrupt controller.
  Assumes a single 40 MHz clock domain and an AHB-Lite register bus.
*/
// Overview of operation
// R01: Eight sources, each with its own three-bit priority level.
// R02: Priority zero never interrupts; levels one to seven may.
// R03: Request to processor interrupt takes at most three clocks.
// R04: Source-specific vector reaches service routine with no core change.
// R05: Preempt running routine only if enabled and strictly higher priority.
// R06: Non-preempting requests stay pending until higher levels finish.
// R07: Write to return register ends the current service level.
// R08: Six controller locations: return, control and four priority registers; the code maps ten, adding event, event clear, event enable and state.
// R09: Each priority register holds two source priorities.
// R10: Control byte resets to all ones; its bits are active low.
// R11: Clear-pending command drops every pending flag at once.
// R12: Disable-after-interrupt blocks further interrupts until allow-one command.
// R13: Global disable blocks interrupts while request flags still latch.
// R14: Bits 2 and 3 are levels; other bits pulse only when written.
// R15: Identical behaviour for internal core and external processor.
// R16: Falling edge on port eight bit seven requests source seven.
// R17: With internal core off, infrared pin outputs the interrupt request.
// R18: Equal priorities are served lowest source number first.
// R19: Vector fetch low address bits are replaced from the source number.
package pvi_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 8;
  localparam int LVL_W   = 3;
  localparam int SRC_W   = 3;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RETURN = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_PRIO0  = 8'h08;
  localparam logic [7:0] ADDR_PRIO1  = 8'h0C;
  localparam logic [7:0] ADDR_PRIO2  = 8'h10;
  localparam logic [7:0] ADDR_PRIO3  = 8'h14;
  localparam logic [7:0] ADDR_EVT    = 8'h18;
  localparam logic [7:0] ADDR_EVTCLR = 8'h1C;
  localparam logic [7:0] ADDR_EVTEN  = 8'h20;
  localparam logic [7:0] ADDR_STATE  = 8'h24;

  // ----------------------------------------------------------------
  // Control byte fields, all active low
  // ----------------------------------------------------------------
  localparam int CTL_CLR_PEND  = 0;
  localparam int CTL_ALLOW_ONE = 1;
  localparam int CTL_GLB_DIS   = 2;
  localparam int CTL_DIS_AFTER = 3;
  localparam logic [7:0] CTRL_RST = 8'hFF;

  // Priority field positions inside a priority register
  localparam int PRIO_LO_POS = 0;
  localparam int PRIO_HI_POS = 4;

  // ----------------------------------------------------------------
  // Event status bits
  // ----------------------------------------------------------------
  localparam int EVT_ACCEPT  = 0;
  localparam int EVT_RETURN  = 1;
  localparam int EVT_CLEARED = 2;
  localparam int EVT_BAD_RET = 3;
  localparam int EVT_W       = 4;

  // State register field positions
  localparam int ST_PEND_POS = 0;
  localparam int ST_SERV_POS = 8;
  localparam int ST_VEC_POS  = 16;
  localparam int ST_BLK_POS  = 19;
  localparam int ST_IRQ_POS  = 20;

  // ----------------------------------------------------------------
  // AHB constants
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             irq_n;
    logic [SRC_W-1:0] vec_src;
  } pvi_cpu_t;

  typedef struct packed {
    logic             out;
    logic             oe;
  } pvi_pin_t;

endpackage

// File: testbench/pvi_top_asserts.sv
/*
  Port checker for pvi_top.
  Assumes one clock domain and a bind to the top module.
*/
module pvi_top_asserts
  import pvi_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        vector_fetch,
  input wire logic        cpu_off,
  input wire pvi_cpu_t    cpu,
  input wire pvi_pin_t    infrared_input_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       rd_ff;
  logic       wr_ff;
  logic [7:0] adr_ff;
  logic [7:0] ctl_ff;

  // ----------------
  // Bus shadow
  // ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff  <= 1'b0;
      wr_ff  <= 1'b0;
      adr_ff <= 8'h00;
    end else begin
      rd_ff  <= hsel & hready & htrans[1] & ~hwrite;
      wr_ff  <= hsel & hready & htrans[1] & hwrite;
      adr_ff <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_ff <= CTRL_RST;
    end else if (wr_ff && adr_ff == ADDR_CTRL) begin
      ctl_ff <= hwdata[7:0];
    end
  end

  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus not ready or not okay");
  zero_read_a: assert property (rd_ff && (adr_ff == 8'hFF || adr_ff == ADDR_RETURN) |-> hrdata == 32'h0000_0000)
    else $error("empty location read nonzero");
  ctrl_read_a: assert property (rd_ff && adr_ff == ADDR_CTRL |-> hrdata[7:0] == ctl_ff)
    else $error("control byte readback wrong");
  glb_hold_a: assert property (!ctl_ff[CTL_GLB_DIS] && cpu.irq_n |=> cpu.irq_n)
    else $error("interrupt while disabled");
  accept_drop_a: assert property ($rose(vector_fetch) && !cpu.irq_n |=> cpu.irq_n)
    else $error("request not dropped on fetch");
  vec_hold_a: assert property ($past(vector_fetch) |-> $stable(cpu.vec_src))
    else $error("vector moved during fetch");
  pin_copy_a: assert property (infrared_input_pin.out == $past(cpu.irq_n))
    else $error("pin does not follow request");
  pin_drive_a: assert property (infrared_input_pin.oe == $past(cpu_off))
    else $error("pin enable wrong");
endmodule

bind pvi_top pvi_top_asserts pvi_top_asserts_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .vector_fetch, .cpu_off, .cpu, .infrared_input_pin
);

// File: testbench/pvi_cpu_model.sv
/*
  Processor model fetching interrupt vectors.
  Assumes go and lag come from the bench.
*/
module pvi_cpu_model
  import pvi_pkg::*;
(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         go,
  input wire logic [3:0]   lag,
  input wire pvi_cpu_t     cpu,
  output logic             vector_fetch,
  output logic [SRC_W-1:0] got,
  output logic [7:0]       n_acc
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_ff;

  // Waits lag cycles, then fetches for two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff       <= 4'h0;
      vector_fetch <= 1'b0;
      got          <= '0;
      n_acc        <= 8'h00;
    end else if (vector_fetch) begin
      cnt_ff       <= cnt_ff + 4'h1;
      vector_fetch <= (cnt_ff == 4'h0);
      // Vector is read in the first fetch cycle
      if (cnt_ff == 4'h0) begin
        got   <= cpu.vec_src;
        n_acc <= n_acc + 8'h01;
      end
    end else if (go && !cpu.irq_n) begin
      if (cnt_ff >= lag) begin
        vector_fetch <= 1'b1;
        cnt_ff       <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end else begin
      cnt_ff <= 4'h0;
    end
  end
endmodule

// File: testbench/test_pvi_top.sv
/*
  Self-checking bench for pvi_top.
  Assumes the processor model answers vector fetches.
*/
module test_pvi_top
  import pvi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] P [8] = '{3'h0, 3'h3, 3'h3, 3'h5, 3'h1, 3'h7, 3'h2, 3'h4};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, evt_irq, vector_fetch;
  logic [6:0]  src_req = '0;
  logic        port8 = 1'b1, cpu_off = 1'b0, go = 1'b0;
  logic [3:0]  lag = 4'h0;
  logic [2:0]  got;
  logic [7:0]  n_acc;
  pvi_cpu_t    cpu;
  pvi_pin_t    pin;
  int          errors = 0, checks_done = 0, cyc = 0;

  always #12.5 hclk = ~hclk;

  pvi_top pvi_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_req, .port8_bit7(port8), .vector_fetch,
    .cpu_off, .cpu, .infrared_input_pin(pin), .evt_irq);
  pvi_cpu_model pvi_cpu_model_inst (.hclk, .hresetn, .go, .lag, .cpu, .vector_fetch, .got, .n_acc);

  // ----------------
  // Tasks
  // ----------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("errors %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h00_0000, a}, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, {24'h00_0000, a}, '0);
    chk(q & m, e);
  endtask

  task take(input logic [2:0] e);
    logic [7:0] m;
    m = n_acc;
    go <= 1'b1;
    while (n_acc === m) @(posedge hclk);
    go <= 1'b0;
    chk(32'(got), 32'(e));
  endtask

  task quiet;
    int n;
    n = 0;
    repeat (6) @(negedge hclk) n += (cpu.irq_n !== 1'b1);
    chk(n, 0);
  endtask

  task src(input int s, input logic v);
    @(posedge hclk);
    if (s == 7) port8 <= ~v;
    else src_req[s] <= v;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_00FF);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_PRIO0 + 8'(4 * k), {25'h0, P[2*k+1], 1'b0, P[2*k]});
      rd(ADDR_PRIO0 + 8'(4 * k), 32'hFFFF_FFFF, {25'h0, P[2*k+1], 1'b0, P[2*k]});
    end
    src(0, 1'b1);
    quiet();
    for (int s = 1; s < 8; s++) begin
      int n;
      lag <= 4'(s);
      src(s, 1'b1);
      n = 0;
      do begin @(negedge hclk); n++; end while (cpu.irq_n !== 1'b0 && n < 9);
      chk(32'(n <= 4), 1);
      take(3'(s));
      wr(ADDR_RETURN, '0);
      src(s, 1'b0);
    end
    src(3, 1'b1);
    take(3'h3);
    src(1, 1'b1);
    src(2, 1'b1);
    quiet();
    src(5, 1'b1);
    take(3'h5);
    wr(ADDR_RETURN, '0);
    quiet();
    wr(ADDR_RETURN, '0);
    take(3'h1);
    wr(ADDR_RETURN, '0);
    take(3'h2);
    wr(ADDR_RETURN, '0);
    @(posedge hclk);
    src_req <= '0;
    cpu_off <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_00FB);
    src(3, 1'b1);
    quiet();
    rd(ADDR_STATE, 32'h0000_00FF, 32'h0000_0009);
    chk(32'(pin.oe), 1);
    wr(ADDR_CTRL, 32'h0000_00FF);
    take(3'h3);
    wr(ADDR_RETURN, '0);
    wr(ADDR_CTRL, 32'h0000_00F7);
    src(4, 1'b1);
    take(3'h4);
    wr(ADDR_RETURN, '0);
    src(6, 1'b1);
    quiet();
    wr(ADDR_CTRL, 32'h0000_00F5);
    take(3'h6);
    wr(ADDR_RETURN, '0);
    src(2, 1'b1);
    quiet();
    wr(ADDR_CTRL, 32'h0000_00FD);
    take(3'h2);
    wr(ADDR_RETURN, '0);
    src(1, 1'b1);
    repeat (4) @(posedge hclk);
    wr(ADDR_CTRL, 32'h0000_00FE);
    rd(ADDR_STATE, 32'h0000_00FF, 32'h0000_0000);
    quiet();
    wr(ADDR_EVTEN, 32'h0000_000F);
    rd(ADDR_EVT, 32'h0000_00FF, 32'h0000_0007);
    chk(32'(evt_irq), 1);
    wr(ADDR_EVTCLR, 32'h0000_0007);
    wr(ADDR_RETURN, '0);
    rd(ADDR_EVT, 32'h0000_00FF, 32'h0000_0008);
    wr(ADDR_EVTEN, 32'h0000_0007);
    bus(1'b0, 32'h0000_0100, '0);
    chk(q, 0);
    chk(32'(evt_irq), 0);
    results();
  end
endmodule
